// ### rtl/operating_mode_controller.sv
// Operating-mode and wake-up controller with classic Wishbone register slave
//
// Notes on behaviour
// - After any reset the controller starts in normal mode on the fast clock.
// - Normal mode runs both oscillators and executes at the fast rate.
// - Slow-select 0 uses fast clock; 1 switches to slow oscillator.
// - Slow mode leaves fast oscillator running until its stop bit is set.
// - Slow mode instruction rate is slow oscillator divided by four.
// - Power-down request stops all oscillators, execution, timers, interrupts.
// - Waking from power down clears the power-down request bit.
// - Power down exits only on port-a or enabled port-b change, to normal.
// - Power-down wake waits 32 fast oscillator clocks before executing.
// - Green request halts execution; clock and wake timer keep running.
// - Waking from green clears the green request bit.
// - Green exits on port-a, port-b change or enabled basic-timer overflow.
// - Green wake returns to the mode it was entered from.
// - Green keeps PWM timer running, but its overflow does not wake.
// - Green wake has no warm-up delay.
// - Fast-stop in normal mode means no clock; acts as power down.
// - Mode field: 00 normal, 01 power down, 10 green, 11 reserved.
// - Fast-stop stops the fast oscillator; slow one runs; clearing restarts.
// - Port-a wake always enabled; four port-b enables, reset to zero.
// - Wake change is either a rising or a falling edge.
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
module operating_mode_controller (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Wake pins and timer events
    input  wire logic [7:0]  port_a_pins_i,
    input  wire logic [3:0]  port_b_pins_i,
    input  wire logic        basic_timer_ovf_i,
    input  wire logic        pwm_timer_ovf_i,
    // Oscillator and core controls
    output logic             high_osc_en_o,
    output logic             low_osc_en_o,
    output logic             sys_clk_slow_o,
    output logic             cpu_run_o,
    output logic             timers_active_o,
    output logic             pwm_active_o,
    output logic             irq_active_o,
    output logic             basic_timer_flag_o
);

    // Register state
    opmode_pkg::osc_ctrl_t  ctrl_r, ctrl_nxt;
    opmode_pkg::op_state_t  state_r, state_nxt;
    logic [3:0]  port_b_wake_enable_r;
    logic        basic_timer_enable_r;
    logic        basic_timer_flag_r, basic_timer_flag_nxt;
    logic        green_from_slow_r;
    logic [9:0]  warm_cnt_r, warm_cnt_nxt;
    logic [7:0]  pa_s1_r, pa_s2_r, pa_s3_r;
    logic [3:0]  pb_s1_r, pb_s2_r, pb_s3_r;
    logic        ack_r;
    logic [31:0] rdat_r;

    // Bus decode
    wire bus_req   = cyc_i & stb_i & ~ack_r;
    wire wr_lane0  = bus_req & we_i & sel_i[0];
    wire hit_ctrl  = adr_i == opmode_pkg::OSC_CTRL_ADDR;
    wire hit_wake  = adr_i == opmode_pkg::WAKE_EN_ADDR;
    wire hit_stat  = adr_i == opmode_pkg::STATUS_ADDR;
    wire hit_timer = adr_i == opmode_pkg::TIMER_CTL_ADDR;
    wire wr_ctrl   = wr_lane0 & hit_ctrl;
    wire wr_wake   = wr_lane0 & hit_wake;
    wire wr_timer  = wr_lane0 & hit_timer;

    // Any level change on a wake pin, after two-flop synchronising
    wire [7:0] pa_chg    = pa_s2_r ^ pa_s3_r;
    wire [3:0] pb_chg    = (pb_s2_r ^ pb_s3_r) & port_b_wake_enable_r;
    wire       pin_wake  = |pa_chg | |pb_chg;
    wire       tmr_wake  = basic_timer_ovf_i & basic_timer_enable_r;

    wire in_pdown = state_r == opmode_pkg::ST_PDOWN;
    wire in_green = state_r == opmode_pkg::ST_GREEN;
    wire in_warm  = state_r == opmode_pkg::ST_WARMUP;
    wire running  = state_r == opmode_pkg::ST_NORMAL
                  | state_r == opmode_pkg::ST_SLOW;

    // Control register next value: writes, then hardware clears on wake
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt.high_osc_stop     = dat_i[opmode_pkg::HIGH_OSC_STOP_BIT];
            ctrl_nxt.slow_clock_select = dat_i[opmode_pkg::SLOW_CLK_SEL_BIT];
            ctrl_nxt.cpu_mode_field    =
                dat_i[opmode_pkg::MODE_FIELD_LSB +: 2];
        end
        // Power-down wake clears the mode field and slow select, and fast-stop if slow select was clear
        if (in_pdown && pin_wake) begin
            ctrl_nxt.cpu_mode_field = opmode_pkg::MODE_NORMAL;
            if (!ctrl_r.slow_clock_select) begin
                ctrl_nxt.high_osc_stop = 1'b0;
            end
            ctrl_nxt.slow_clock_select = 1'b0;
        end
        if (in_green && (pin_wake || tmr_wake)) begin
            ctrl_nxt.cpu_mode_field = opmode_pkg::MODE_NORMAL;
        end
    end

    // Mode sequencer; decode acts on the registered field, one cycle after the write
    always_comb begin
        state_nxt    = state_r;
        warm_cnt_nxt = warm_cnt_r;
        unique case (state_r)
            opmode_pkg::ST_NORMAL, opmode_pkg::ST_SLOW: begin
                unique case (ctrl_r.cpu_mode_field)
                    opmode_pkg::MODE_PDOWN:
                        state_nxt = opmode_pkg::ST_PDOWN;
                    opmode_pkg::MODE_GREEN:
                        state_nxt = opmode_pkg::ST_GREEN;
                    opmode_pkg::MODE_NORMAL, opmode_pkg::MODE_RESERVED: begin
                        // Reserved code keeps executing mode
                        if (!ctrl_r.slow_clock_select
                            && ctrl_r.high_osc_stop) begin
                            state_nxt = opmode_pkg::ST_PDOWN;
                        end else if (ctrl_r.slow_clock_select) begin
                            state_nxt = opmode_pkg::ST_SLOW;
                        end else begin
                            state_nxt = opmode_pkg::ST_NORMAL;
                        end
                    end
                endcase
            end
            opmode_pkg::ST_GREEN: begin
                // PWM overflow deliberately not a wake source
                if (pin_wake || tmr_wake) begin
                    state_nxt = green_from_slow_r
                              ? opmode_pkg::ST_SLOW
                              : opmode_pkg::ST_NORMAL;
                end
            end
            opmode_pkg::ST_PDOWN: begin
                if (pin_wake) begin
                    state_nxt    = opmode_pkg::ST_WARMUP;
                    warm_cnt_nxt = opmode_pkg::WARMUP_CYCLES;
                end
            end
            opmode_pkg::ST_WARMUP: begin
                if (warm_cnt_r == 10'h001) begin
                    state_nxt = opmode_pkg::ST_NORMAL;
                end
                warm_cnt_nxt = warm_cnt_r - 10'h001;
            end
            default: state_nxt = opmode_pkg::ST_NORMAL;
        endcase
    end

    // Timer request flag: an overflow wins over a software clear
    always_comb begin
        basic_timer_flag_nxt = basic_timer_flag_r;
        if (wr_timer && !dat_i[1]) begin
            basic_timer_flag_nxt = 1'b0;
        end
        if (basic_timer_ovf_i && !in_pdown && !in_warm) begin
            basic_timer_flag_nxt = 1'b1;
        end
    end

    // Read data mux
    wire [31:0] rd_mux =
        hit_ctrl  ? {27'h0, ctrl_r, 1'b0} :
        hit_wake  ? {28'h0, port_b_wake_enable_r} :
        hit_stat  ? {29'h0, state_r} :
        hit_timer ? {30'h0, basic_timer_flag_r, basic_timer_enable_r} :
        32'h0;

    // Pin synchronisers; the third stage is the change reference
    always_ff @(posedge clk_i) begin
        pa_s1_r <= port_a_pins_i;
        pa_s2_r <= pa_s1_r;
        pa_s3_r <= pa_s2_r;
        pb_s1_r <= port_b_pins_i;
        pb_s2_r <= pb_s1_r;
        pb_s3_r <= pb_s2_r;
    end

    // Control state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r               <= opmode_pkg::OSC_CTRL_RST[4:1];
            state_r              <= opmode_pkg::ST_NORMAL;
            port_b_wake_enable_r <= opmode_pkg::WAKE_EN_RST;
            basic_timer_enable_r <= 1'b0;
            basic_timer_flag_r   <= 1'b0;
            green_from_slow_r    <= 1'b0;
            warm_cnt_r           <= 10'h000;
        end else begin
            ctrl_r             <= ctrl_nxt;
            state_r            <= state_nxt;
            warm_cnt_r         <= warm_cnt_nxt;
            basic_timer_flag_r <= basic_timer_flag_nxt;
            if (running) begin
                green_from_slow_r <= state_r == opmode_pkg::ST_SLOW;
            end
            if (wr_wake) begin
                port_b_wake_enable_r <= dat_i[3:0];
            end
            if (wr_timer) begin
                basic_timer_enable_r <= dat_i[0];
            end
        end
    end

    // Bus answer: one wait state, ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r  <= bus_req;
            rdat_r <= bus_req ? rd_mux : 32'h0;
        end
    end

    // Registered outputs derived from next state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_osc_en_o      <= 1'b1;
            low_osc_en_o       <= 1'b1;
            sys_clk_slow_o     <= 1'b0;
            cpu_run_o          <= 1'b1;
            timers_active_o    <= 1'b1;
            pwm_active_o       <= 1'b1;
            irq_active_o       <= 1'b1;
        end else begin
            high_osc_en_o   <= state_nxt != opmode_pkg::ST_PDOWN
                             & ~ctrl_nxt.high_osc_stop;
            low_osc_en_o    <= state_nxt != opmode_pkg::ST_PDOWN;
            sys_clk_slow_o  <= state_nxt == opmode_pkg::ST_SLOW
                             | (state_nxt == opmode_pkg::ST_GREEN
                                & green_from_slow_r);
            cpu_run_o       <= state_nxt == opmode_pkg::ST_NORMAL
                             | state_nxt == opmode_pkg::ST_SLOW;
            timers_active_o <= state_nxt != opmode_pkg::ST_PDOWN
                             & state_nxt != opmode_pkg::ST_WARMUP;
            pwm_active_o    <= state_nxt != opmode_pkg::ST_PDOWN
                             & state_nxt != opmode_pkg::ST_WARMUP;
            irq_active_o    <= state_nxt != opmode_pkg::ST_PDOWN
                             & state_nxt != opmode_pkg::ST_WARMUP;
        end
    end

    assign dat_o              = rdat_r;
    assign ack_o              = ack_r;
    assign basic_timer_flag_o = basic_timer_flag_r;

    // Checks
    a_warmup_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(in_warm) |-> in_warm [*8] ##0 1'b1)
        else $error("warm-up ended early");
    a_pdown_wake_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        in_pdown && pin_wake |=> ctrl_r.cpu_mode_field == 2'h0)
        else $error("power-down bit not cleared");
    a_pdown_no_timer: assert property (@(posedge clk_i) disable iff (rst_i)
        in_pdown && !pin_wake |=> in_pdown)
        else $error("power down left without pin wake");
    a_green_return: assert property (@(posedge clk_i) disable iff (rst_i)
        in_green && tmr_wake && green_from_slow_r
        |=> state_r == opmode_pkg::ST_SLOW)
        else $error("green did not return to slow");
    a_green_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        in_green && pin_wake |=> ctrl_r.cpu_mode_field == 2'h0)
        else $error("green bit not cleared");
    a_green_pwm_nowake: assert property (@(posedge clk_i) disable iff (rst_i)
        in_green && !pin_wake && !tmr_wake |=> in_green)
        else $error("green woke without source");
    a_pdown_osc_off: assert property (@(posedge clk_i) disable iff (rst_i)
        in_pdown |-> !low_osc_en_o && !cpu_run_o)
        else $error("oscillator on in power down");
    a_green_halts: assert property (@(posedge clk_i) disable iff (rst_i)
        in_green |-> !cpu_run_o && low_osc_en_o)
        else $error("cpu running in green");
    a_reserved_stays: assert property (@(posedge clk_i) disable iff (rst_i)
        running && ctrl_r.cpu_mode_field == 2'h3 |=> running)
        else $error("reserved code left running mode");
    c_pdown_wake: cover property (@(posedge clk_i) in_warm ##1 !in_warm);
    c_green_timer: cover property (@(posedge clk_i) in_green && tmr_wake);
    c_slow_mode: cover property (@(posedge clk_i)
        state_r == opmode_pkg::ST_SLOW);
    c_green_slow_back: cover property (@(posedge clk_i)
        in_green && green_from_slow_r ##1 state_r == opmode_pkg::ST_SLOW);
    c_fast_stop_pdown: cover property (@(posedge clk_i)
        state_r == opmode_pkg::ST_NORMAL && ctrl_r.high_osc_stop
        ##1 in_pdown);

    // Helper: cycles spent in warm-up; a repetition of 400 is too long
    logic [9:0] warm_seen_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || !in_warm) begin
            warm_seen_r <= 10'h000;
        end else begin
            warm_seen_r <= warm_seen_r + 10'h001;
        end
    end

    // Warm-up must run its full length before execution resumes
    a_warmup_count: assert property (@(posedge clk_i) disable iff (rst_i)
        in_warm && state_nxt != opmode_pkg::ST_WARMUP
        |-> warm_seen_r == opmode_pkg::WARMUP_CYCLES - 10'h001)
        else $error("warm-up length wrong");

    // Output levels must match the mode that the sequencer holds
    a_reset_normal: assert property (@(posedge clk_i)
        rst_i |=> state_r == opmode_pkg::ST_NORMAL && cpu_run_o)
        else $error("reset did not give normal mode");
    a_normal_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == opmode_pkg::ST_NORMAL
        |-> low_osc_en_o && cpu_run_o && !sys_clk_slow_o)
        else $error("normal mode levels wrong");
    a_slow_clock: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == opmode_pkg::ST_SLOW |-> sys_clk_slow_o && cpu_run_o)
        else $error("slow mode levels wrong");
    a_pdown_all_off: assert property (@(posedge clk_i) disable iff (rst_i)
        in_pdown |-> !high_osc_en_o && !timers_active_o && !irq_active_o)
        else $error("block active in power down");
    a_green_keeps_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
        in_green |-> pwm_active_o && timers_active_o)
        else $error("timers stopped in green");
    a_green_no_warm: assert property (@(posedge clk_i) disable iff (rst_i)
        in_green && (pin_wake || tmr_wake) |=> !in_warm && cpu_run_o)
        else $error("green wake was delayed");

    // A set in the same cycle as a software clear must win
    a_timer_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        basic_timer_ovf_i && !in_pdown && !in_warm
        |=> basic_timer_flag_o)
        else $error("timer flag not set");

    // The bus answer is a single-cycle pulse
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held too long");

endmodule : operating_mode_controller

// ### rtl/opmode_pkg.sv
// Package: register map, field layout, modes and timing for the mode controller
package opmode_pkg;

    // Register byte addresses
    localparam logic [7:0] OSC_CTRL_ADDR  = 8'h00;
    localparam logic [7:0] WAKE_EN_ADDR   = 8'h04;
    localparam logic [7:0] STATUS_ADDR    = 8'h08;
    localparam logic [7:0] TIMER_CTL_ADDR = 8'h0c;

    // Oscillator control field positions
    localparam int HIGH_OSC_STOP_BIT = 1;
    localparam int SLOW_CLK_SEL_BIT  = 2;
    localparam int MODE_FIELD_LSB    = 3;

    // Mode field codes
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_PDOWN    = 2'h1;
    localparam logic [1:0] MODE_GREEN    = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // Reset values
    localparam logic [7:0] OSC_CTRL_RST = 8'h00;
    localparam logic [3:0] WAKE_EN_RST  = 4'h0;

    // Warm-up after power-down wake, given in high-speed oscillator clocks, counted in clk_i cycles
    localparam int          WARMUP_OSC_CLKS = 32;
    localparam int          HOSC_FREQ_MHZ   = 16;
    localparam int          CLK_FREQ_MHZ    = 200;
    localparam logic [9:0]  WARMUP_CYCLES   =
        10'((WARMUP_OSC_CLKS * CLK_FREQ_MHZ + HOSC_FREQ_MHZ - 1)
            / HOSC_FREQ_MHZ);

    // Controller states
    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_SLOW,
        ST_GREEN,
        ST_PDOWN,
        ST_WARMUP
    } op_state_t;

    // Software control bits carried together
    typedef struct packed {
        logic [1:0] cpu_mode_field;
        logic       slow_clock_select;
        logic       high_osc_stop;
    } osc_ctrl_t;

endpackage : opmode_pkg

// ### test/operating_mode_controller_tb_top.sv
// Testbench: mode entry and wake-up sequences over the register bus
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module operating_mode_controller_tb_top;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i;
    logic [7:0]  adr_i, pa;
    logic [3:0]  sel_i, pb;
    logic [31:0] dat_i, dat_o, q;
    logic        ack_o, bto, pwo, hosc, losc, slow, run, tmr, pwm, irq, flg;
    int          errors = 0;
    int          checked = 0;
    int          n;

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    operating_mode_controller operating_mode_controller_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .port_a_pins_i(pa),
        .port_b_pins_i(pb), .basic_timer_ovf_i(bto), .pwm_timer_ovf_i(pwo),
        .high_osc_en_o(hosc), .low_osc_en_o(losc), .sys_clk_slow_o(slow),
        .cpu_run_o(run), .timers_active_o(tmr), .pwm_active_o(pwm),
        .irq_active_o(irq), .basic_timer_flag_o(flg));

    wake_source_model wake_source_model_inst (
        .clk_i(clk_i), .port_a_pins_o(pa), .port_b_pins_o(pb),
        .basic_timer_ovf_o(bto), .pwm_timer_ovf_o(pwo));

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50)
            errors++;
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    // Let wake synchronisers settle, then compare the state code
    task automatic expect_state(input opmode_pkg::op_state_t s);
        repeat (6) @(posedge clk_i);
        wb(1'b0, opmode_pkg::STATUS_ADDR, 32'h0);
        `CHK(q, 32'(s))
    endtask : expect_state

    task automatic expect_ctrl(input logic [31:0] e);
        wb(1'b0, opmode_pkg::OSC_CTRL_ADDR, 32'h0);
        `CHK(q, e)
    endtask : expect_ctrl

    // Bounded wait for execution to resume; warm-up must be ~400 cycles
    task automatic wait_run();
        n = 0;
        while (run !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n >= 400 && n <= 410, 1'b1)
    endtask : wait_run

    task automatic give_verdict();
        $display("counts: checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Watchdog well beyond the expected run of about a thousand cycles
    initial begin
        #100us;
        errors++;
        give_verdict();
    end

    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {4'h8, 40'h0, 4'hf};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        expect_state(opmode_pkg::ST_NORMAL);
        `CHK({hosc, losc, slow, run}, 4'hd)
        expect_ctrl(32'h0);
        wb(1'b0, opmode_pkg::WAKE_EN_ADDR, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
        $display("test reset done");
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h04);
        expect_state(opmode_pkg::ST_SLOW);
        `CHK({hosc, slow, run}, 3'h7)
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h06);
        repeat (3) @(posedge clk_i);
        `CHK({hosc, losc, slow}, 3'h3)
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h18);
        expect_state(opmode_pkg::ST_NORMAL);
        `CHK({hosc, slow, run}, 3'h5)
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h00);
        $display("test slow and reserved done");
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h10);
        expect_state(opmode_pkg::ST_GREEN);
        `CHK({run, hosc, tmr, pwm}, 4'h7)
        wake_source_model_inst.pulse(1'b1);
        expect_state(opmode_pkg::ST_GREEN);
        wake_source_model_inst.pulse(1'b0);
        expect_state(opmode_pkg::ST_GREEN);
        `CHK(flg, 1'b1)
        wb(1'b1, opmode_pkg::TIMER_CTL_ADDR, 32'h1);
        wake_source_model_inst.pulse(1'b0);
        repeat (4) @(posedge clk_i);
        `CHK(run, 1'b1)
        expect_state(opmode_pkg::ST_NORMAL);
        expect_ctrl(32'h0);
        wb(1'b1, opmode_pkg::TIMER_CTL_ADDR, 32'h0);
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h04);
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h14);
        expect_state(opmode_pkg::ST_GREEN);
        wake_source_model_inst.flip(1'b0, 3);
        expect_state(opmode_pkg::ST_SLOW);
        expect_ctrl(32'h04);
        $display("test green done");
        wb(1'b1, opmode_pkg::WAKE_EN_ADDR, 32'h4);
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h0c);
        expect_state(opmode_pkg::ST_PDOWN);
        `CHK({hosc, losc, run, tmr, pwm, irq}, 6'h0)
        wake_source_model_inst.flip(1'b1, 1);
        expect_state(opmode_pkg::ST_PDOWN);
        wake_source_model_inst.pulse(1'b0);
        expect_state(opmode_pkg::ST_PDOWN);
        wake_source_model_inst.flip(1'b1, 2);
        wait_run();
        expect_state(opmode_pkg::ST_NORMAL);
        `CHK({hosc, losc, slow}, 3'h6)
        expect_ctrl(32'h0);
        wb(1'b1, opmode_pkg::OSC_CTRL_ADDR, 32'h02);
        expect_state(opmode_pkg::ST_PDOWN);
        `CHK({hosc, run}, 2'h0)
        wake_source_model_inst.flip(1'b0, 0);
        wait_run();
        expect_ctrl(32'h0);
        $display("test power down done");
        give_verdict();
    end
endmodule : operating_mode_controller_tb_top

// ### test/wake_source_model.sv
// Partner model: wake pins with pull-ups and timer overflow pulses
`timescale 1ns/1ps
module wake_source_model (
    // Clock
    input  wire logic       clk_i,
    // Wake pins and timer events towards the controller
    output logic      [7:0] port_a_pins_o,
    output logic      [3:0] port_b_pins_o,
    output logic            basic_timer_ovf_o,
    output logic            pwm_timer_ovf_o
);
    // Pins rest high through their pull-ups
    initial begin
        port_a_pins_o     = 8'hff;
        port_b_pins_o     = 4'hf;
        basic_timer_ovf_o = 1'b0;
        pwm_timer_ovf_o   = 1'b0;
    end

    // Level change on one pin; either direction must wake
    task automatic flip(input logic is_b, input int idx);
        @(posedge clk_i);
        if (is_b)
            port_b_pins_o[idx] <= ~port_b_pins_o[idx];
        else
            port_a_pins_o[idx] <= ~port_a_pins_o[idx];
    endtask : flip

    // One-cycle overflow pulse of either timer
    task automatic pulse(input logic is_pwm);
        @(posedge clk_i);
        if (is_pwm)
            pwm_timer_ovf_o <= 1'b1;
        else
            basic_timer_ovf_o <= 1'b1;
        @(posedge clk_i);
        pwm_timer_ovf_o   <= 1'b0;
        basic_timer_ovf_o <= 1'b0;
    endtask : pulse
endmodule : wake_source_model
